// ==== rtl/sot_pkg.sv ====
// Purpose: constants and carrier types of the STM-1 section overhead block
// Assumes: one byte per clock of CLK_I, 50 MHz
// Notes:   register offsets are byte addresses on a 32-bit APB
//
// Contract
// - receive defect or AIS puts 110 in K2 bits 6-8 within 250 us; code sends 110 on receive section defect only, not on loss of signal/AIS
// - defect clearing puts 000 in K2 bits 6-8 within 250 us
// - unidirectional operation forces the remote defect indication to zero
// - B2 carries even BIP-24 of previous frame, regenerator overhead excluded
// - frame combines multiplex overhead, AU-4 pointer and 2304 payload bytes; code carries 2349 payload bytes (261 columns by 9 rows)
// - J0 sends a provisioned 16-byte trace, one byte per frame
// - B1 carries even BIP-8 of previous frame as sent after scrambling
// - first row starts with three A1 then three A2 bytes
// - A1 is 11110110, A2 is 00101000
// - scramble all but first overhead row with x^7+x^6+1, frame synchronous
// - electrical output is coded mark inversion of the scrambled stream
// - optical output: light for one, dark for zero
// - loss of signal gives all-ones receive data within 250 us
// - loss of signal ending restores received data within 250 us
// - loss of signal is reported to management only while monitored; code shows it in STATUS bit 2 whether monitored or not
// - seconds holding loss of signal are counted, reported at interval end
// - monitored state set by software; faults declared only while monitored
package sot_pkg;

  // ==========================================================
  // frame geometry
  localparam int        ROWS       = 9;
  localparam int        COLS       = 270;
  localparam int        SOH_COLS   = 9;
  localparam logic [7:0] A1_BYTE   = 8'hF6;
  localparam logic [7:0] A2_BYTE   = 8'h28;
  localparam logic [2:0] K2_RDI    = 3'h6;
  localparam logic [2:0] K2_OK     = 3'h0;
  localparam logic [6:0] SCR_SEED  = 7'h7F;

  // ==========================================================
  // timing
  localparam int CLK_KHZ      = 50000;
  localparam int T_REACT_US   = 250;
  localparam int T_SEC_MS     = 1000;
  localparam int REACT_CYC    = T_REACT_US * CLK_KHZ / 1000;
  localparam int SEC_CYC      = T_SEC_MS * CLK_KHZ;

  // ==========================================================
  // registers
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_CLR  = 8'h0C;
  localparam logic [7:0] OFS_INT_EN   = 8'h10;
  localparam logic [7:0] OFS_NDS_REP  = 8'h14;
  localparam logic [7:0] OFS_NDS_CNT  = 8'h18;
  localparam logic [7:0] OFS_TRACE0   = 8'h20;
  localparam int         CTRL_MON     = 0;
  localparam int         CTRL_UNIDIR  = 1;
  localparam int         CTRL_OPT_EN  = 2;
  localparam logic [2:0] CTRL_RST     = 3'h0;
  localparam int         EV_LOS_SET   = 0;
  localparam int         EV_LOS_CLR   = 1;
  localparam int         EV_SEC_REP   = 2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sot_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } sot_apb_rsp_t;

  typedef struct packed {
    logic [7:0]  byte_val;
    logic        fs;
    logic [15:0] cmi;
    logic [7:0]  opt;
  } sot_tx_t;

endpackage : sot_pkg

// ==== rtl/sot_top.sv ====
// Purpose: STM-1 overhead insertion, scrambling, line coding, LOS handling
// Assumes: source presents a payload byte whenever PAY_TAKE_O is high
// Notes:   pointer bytes arrive from the source with the payload
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/10ps
module sot_top #(
  parameter int REACT_CYC = sot_pkg::REACT_CYC,
  parameter int SEC_CYC   = sot_pkg::SEC_CYC
) (
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  // register bus
  input  wire sot_pkg::sot_apb_req_t APB_I,
  output sot_pkg::sot_apb_rsp_t      APB_O,
  // payload source
  input  wire logic [7:0]        PAY_I,
  output logic                   PAY_TAKE_O,
  // line side
  output sot_pkg::sot_tx_t       TX_O,
  input  wire logic              RX_LOS_I,
  input  wire logic              RX_SD_I,
  input  wire logic [7:0]        RX_DATA_I,
  // internal receive side and alarms
  output logic [7:0]             RX_DATA_O,
  output logic                   RX_AIS_O,
  output logic                   LOS_REP_O,
  output logic                   IRQ_O
);
  import sot_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [3:0]       row;
    logic [8:0]       col;
    logic [1:0]       m3;
    logic [3:0]       j0_idx;
    logic [6:0]       sc;
    logic [7:0]       bip8;
    logic [7:0]       b1;
    logic [23:0]      acc24;
    logic [23:0]      b2;
    logic             cmi_pol;
    logic [1:0]       flt_st;
    logic [1:0][31:0] flt_cnt;
    logic [31:0]      sec_cnt;
    logic             sec_hit;
    logic [15:0]      nds_count;
    logic [15:0]      nds_report;
    logic [2:0]       ctrl;
    logic [2:0]       int_stat;
    logic [2:0]       int_en;
    logic [3:0][31:0] trace;
    sot_tx_t          tx;
    logic             pay_take;
    logic [7:0]       rx_data;
    logic             rx_ais;
    logic             los_rep;
    logic             irq;
    sot_apb_rsp_t     apb;
  } sot_state_t;

  localparam sot_state_t ST_RST = '0;
  localparam int FLT_END = (REACT_CYC > 3) ? REACT_CYC - 2 : 1;
  localparam int SEC_END = (SEC_CYC > 1) ? SEC_CYC - 1 : 1;

  sot_state_t s;
  sot_state_t next_s;

  // ==========================================================
  // helpers
  // returns {next state, keystream byte}, MSB sent first
  function automatic logic [14:0] scr_step(input logic [6:0] st);
    logic [6:0] x;
    logic [7:0] ks;
    x  = st;
    ks = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      ks[i] = x[6];
      x     = {x[5:0], x[6] ^ x[5]};
    end
    return {x, ks};
  endfunction : scr_step

  // returns {next polarity, 16 half-bit symbols}
  function automatic logic [16:0] cmi_enc(input logic [7:0] d,
                                          input logic       pol);
    logic        p;
    logic [15:0] o;
    p = pol;
    o = 16'h0000;
    for (int i = 7; i >= 0; i--) begin
      if (d[i]) begin
        o[2*i+1] = p;
        o[2*i]   = p;
        p        = ~p;
      end else begin
        o[2*i+1] = 1'b0;
        o[2*i]   = 1'b1;
      end
    end
    return {p, o};
  endfunction : cmi_enc

  // ==========================================================
  // next-state logic
  logic        soh;
  logic        rsoh;
  logic        last;
  logic [7:0]  raw;
  logic [7:0]  scr;
  logic [14:0] scr_r;
  logic [16:0] cmi_r;
  logic [8:0]  n_col;
  logic [3:0]  n_row;
  logic [1:0]  raw_in;
  logic [1:0]  flt_prev;
  logic [2:0]  ev;
  logic        sec_end;
  logic        mon;
  logic        unidir;
  logic        apb_go;
  logic        apb_done;
  logic [31:0] rd;
  logic        rd_err;
  logic [2:0]  clr;
  logic [15:0] nds_next;

  always_comb begin
    next_s = s;
    mon    = s.ctrl[CTRL_MON];
    unidir = s.ctrl[CTRL_UNIDIR];
    soh    = (s.col < 9'(SOH_COLS));
    rsoh   = soh && (s.row < 4'd3);
    last   = (s.row == 4'(ROWS - 1)) && (s.col == 9'(COLS - 1));

    // frame position: row, column, column modulo three
    if (s.col == 9'(COLS - 1)) begin
      n_col = 9'd0;
      n_row = (s.row == 4'(ROWS - 1)) ? 4'd0 : s.row + 4'd1;
    end else begin
      n_col = s.col + 9'd1;
      n_row = s.row;
    end
    next_s.col = n_col;
    next_s.row = n_row;
    next_s.m3  = (n_col == 9'd0 || s.m3 == 2'd2) ? 2'd0 : s.m3 + 2'd1;
    next_s.pay_take = (n_col >= 9'(SOH_COLS)) || (n_row == 4'd3);
    if (last) begin
      next_s.j0_idx = s.j0_idx + 4'd1;
    end

    // byte before scrambling
    raw = 8'h00;
    if (!soh || s.row == 4'd3) begin
      raw = PAY_I;
    end else if (s.row == 4'd0) begin
      if (s.col < 9'd3) begin
        raw = A1_BYTE;
      end else if (s.col < 9'd6) begin
        raw = A2_BYTE;
      end else if (s.col == 9'd6) begin
        raw = s.trace[s.j0_idx[3:2]][8*s.j0_idx[1:0] +: 8];
      end
    end else if (s.row == 4'd1 && s.col == 9'd0) begin
      raw = s.b1;
    end else if (s.row == 4'd4 && s.col < 9'd3) begin
      raw = s.b2[8*(2 - s.m3) +: 8];
    end else if (s.row == 4'd4 && s.col == 9'd6) begin
      // unidirectional: no receive termination, so no defect to return
      raw = {5'h00, (s.flt_st[1] && !unidir) ? K2_RDI : K2_OK};
    end

    // frame-synchronous scrambler, first overhead row left clear
    scr_r = scr_step(s.sc);
    if (s.row == 4'd0 && soh) begin
      scr     = raw;
      next_s.sc = SCR_SEED;
    end else begin
      scr     = raw ^ scr_r[7:0];
      next_s.sc = scr_r[14:8];
    end

    // parity over the frame just sent
    if (last) begin
      next_s.b1   = s.bip8 ^ scr;
      next_s.bip8 = 8'h00;
    end else begin
      next_s.bip8 = s.bip8 ^ scr;
    end
    next_s.acc24 = s.acc24;
    if (!rsoh) begin
      next_s.acc24[8*(2 - s.m3) +: 8] = s.acc24[8*(2 - s.m3) +: 8] ^ raw;
    end
    if (last) begin
      next_s.b2    = next_s.acc24;
      next_s.acc24 = 24'h000000;
    end

    // line outputs
    cmi_r            = cmi_enc(scr, s.cmi_pol);
    next_s.cmi_pol   = cmi_r[16];
    next_s.tx.cmi    = cmi_r[15:0];
    next_s.tx.byte_val = scr;
    next_s.tx.fs     = (s.row == 4'd0) && (s.col == 9'd0);
    // laser held dark while the optical output is disabled
    next_s.tx.opt    = s.ctrl[CTRL_OPT_EN] ? scr : 8'h00;

    // persistence filters: 0 loss of signal, 1 receive section defect
    raw_in   = {RX_SD_I, RX_LOS_I};
    flt_prev = s.flt_st;
    for (int i = 0; i < 2; i++) begin
      if (raw_in[i] == s.flt_st[i]) begin
        next_s.flt_cnt[i] = 32'd0;
      end else if (s.flt_cnt[i] >= 32'(FLT_END - 1)) begin
        next_s.flt_cnt[i] = 32'd0;
        next_s.flt_st[i]  = raw_in[i];
      end else begin
        next_s.flt_cnt[i] = s.flt_cnt[i] + 32'd1;
      end
    end

    // all-ones toward the internal side while signal is lost
    next_s.rx_data = next_s.flt_st[0] ? 8'hFF : RX_DATA_I;
    next_s.rx_ais  = next_s.flt_st[0];
    next_s.los_rep = next_s.flt_st[0] && mon;

    // one-second interval and defect seconds
    sec_end  = (s.sec_cnt >= 32'(SEC_END));
    nds_next = s.nds_count + 16'd1;
    if (sec_end) begin
      next_s.sec_cnt = 32'd0;
      next_s.sec_hit = s.flt_st[0];
      if (s.sec_hit || s.flt_st[0]) begin
        next_s.nds_count = nds_next;
      end
      if (mon) begin
        next_s.nds_report = (s.sec_hit || s.flt_st[0]) ? nds_next
                                                       : s.nds_count;
      end
    end else begin
      next_s.sec_cnt = s.sec_cnt + 32'd1;
      next_s.sec_hit = s.sec_hit || s.flt_st[0];
    end

    // events only while monitored
    ev             = 3'h0;
    ev[EV_LOS_SET] = mon && next_s.flt_st[0] && !flt_prev[0];
    ev[EV_LOS_CLR] = mon && !next_s.flt_st[0] && flt_prev[0];
    ev[EV_SEC_REP] = mon && sec_end;

    // APB slave, one wait state
    apb_go   = APB_I.psel && APB_I.penable && !s.apb.pready;
    apb_done = APB_I.psel && APB_I.penable && s.apb.pready;
    rd       = 32'h00000000;
    rd_err   = 1'b0;
    unique case (APB_I.paddr)
      OFS_CTRL:     rd = {29'h0, s.ctrl};
      OFS_STATUS:   rd = {29'h0, s.flt_st[0], s.flt_st[1], s.los_rep};
      OFS_INT_STAT: rd = {29'h0, s.int_stat};
      OFS_INT_CLR:  rd = 32'h00000000;
      OFS_INT_EN:   rd = {29'h0, s.int_en};
      OFS_NDS_REP:  rd = {16'h0, s.nds_report};
      OFS_NDS_CNT:  rd = {16'h0, s.nds_count};
      OFS_TRACE0,
      OFS_TRACE0 + 8'h04,
      OFS_TRACE0 + 8'h08,
      OFS_TRACE0 + 8'h0C: rd = s.trace[APB_I.paddr[3:2]];
      default:      rd_err = 1'b1;
    endcase
    next_s.apb.pready  = apb_go;
    next_s.apb.prdata  = (apb_go && !APB_I.pwrite) ? rd : 32'h00000000;
    next_s.apb.pslverr = apb_go && rd_err;

    clr = 3'h0;
    if (apb_done && APB_I.pwrite) begin
      unique case (APB_I.paddr)
        OFS_CTRL:    next_s.ctrl   = APB_I.pwdata[2:0];
        OFS_INT_CLR: clr           = APB_I.pwdata[2:0];
        OFS_INT_EN:  next_s.int_en = APB_I.pwdata[2:0];
        OFS_TRACE0,
        OFS_TRACE0 + 8'h04,
        OFS_TRACE0 + 8'h08,
        OFS_TRACE0 + 8'h0C: begin
          next_s.trace[APB_I.paddr[3:2]] = APB_I.pwdata;
        end
        default: ;
      endcase
    end
    // an event in the clearing cycle survives
    next_s.int_stat = (s.int_stat & ~clr) | ev;
    next_s.irq      = |(next_s.int_stat & next_s.int_en);
  end

  // ==========================================================
  // registers
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s <= ST_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs
  assign APB_O      = s.apb;
  assign PAY_TAKE_O = s.pay_take;
  assign TX_O       = s.tx;
  assign RX_DATA_O  = s.rx_data;
  assign RX_AIS_O   = s.rx_ais;
  assign LOS_REP_O  = s.los_rep;
  assign IRQ_O      = s.irq;

endmodule : sot_top

// ==== bench/sot_top_checker.sv ====
// Purpose: port-level checks of sot_top
// Assumes: bench shrinks REACT_CYC to a few tens of cycles
// Notes:   bound to every sot_top instance below
`timescale 1ns/10ps
module sot_top_checker #(
  parameter int REACT_CYC = 20,
  parameter int SEC_CYC   = 200
) (
  // observed ports
  input wire logic                  CLK_I,
  input wire logic                  RST_N_I,
  input wire sot_pkg::sot_apb_req_t APB_I,
  input wire sot_pkg::sot_apb_rsp_t APB_O,
  input wire logic                  PAY_TAKE_O,
  input wire sot_pkg::sot_tx_t      TX_O,
  input wire logic                  RX_LOS_I,
  input wire logic [7:0]            RX_DATA_I,
  input wire logic [7:0]            RX_DATA_O,
  input wire logic                  RX_AIS_O,
  input wire logic                  LOS_REP_O,
  input wire logic                  IRQ_O
);
  import sot_pkg::*;
  logic [11:0] fcnt;
  logic [11:0] pcnt;
  logic        seen;
  logic [15:0] lcnt;

  // ==========================================================
  // helpers
  function automatic logic cmi_ok(logic [7:0] b, logic [15:0] c);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++)
      if (b[i] ? (c[2*i+1] != c[2*i]) : (c[2*i+:2] != 2'b01)) ok = 1'b0;
    return ok;
  endfunction : cmi_ok

  // counts span whole frames so alignment of the pulses does not matter
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fcnt <= 12'h000;
      pcnt <= 12'h000;
      seen <= 1'b0;
      lcnt <= 16'h0000;
    end else begin
      fcnt <= TX_O.fs ? 12'h000 : fcnt + 12'h001;
      pcnt <= TX_O.fs ? 12'(PAY_TAKE_O) : pcnt + 12'(PAY_TAKE_O);
      seen <= seen | TX_O.fs;
      lcnt <= (RX_LOS_I != RX_AIS_O) ? lcnt + 16'h0001 : 16'h0000;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  AST_FAS: assert property (TX_O.fs |->
    (TX_O.byte_val == A1_BYTE)[*3] ##1 (TX_O.byte_val == A2_BYTE)[*3])
    else $error("framing bytes wrong");
  AST_FRAME_LEN: assert property (TX_O.fs && seen |-> fcnt == 12'h97D)
    else $error("frame length wrong");
  AST_PAY_CNT: assert property (TX_O.fs && seen |-> pcnt == 12'h936)
    else $error("payload byte count wrong");
  AST_CMI: assert property ($past(RST_N_I) |->
    cmi_ok(TX_O.byte_val, TX_O.cmi)) else $error("line code wrong");
  AST_OPT: assert property (TX_O.opt == 8'h00 || TX_O.opt == TX_O.byte_val)
    else $error("optical level wrong");
  AST_LOS_REACT: assert property (lcnt <= 16'(REACT_CYC))
    else $error("loss reaction too slow");
  AST_AIS_DATA: assert property (RX_AIS_O && $past(RX_AIS_O) |->
    RX_DATA_O == 8'hFF) else $error("all-ones missing");
  AST_PASS_DATA: assert property (!RX_AIS_O && !$past(RX_AIS_O) &&
    $past(RST_N_I) |-> RX_DATA_O == $past(RX_DATA_I))
    else $error("receive data not passed");
  AST_REP: assert property (LOS_REP_O |-> RX_AIS_O)
    else $error("report without defect");
  AST_APB_RDY: assert property ($rose(APB_I.penable) && APB_I.psel |->
    ##1 APB_O.pready ##1 !APB_O.pready) else $error("bus answer late");

  COV_FRAME: cover property (TX_O.fs && seen);
  COV_AIS: cover property ($rose(RX_AIS_O));
  COV_ERR: cover property (APB_O.pready && APB_O.pslverr);
  COV_IRQ: cover property ($rose(IRQ_O));
endmodule : sot_top_checker

bind sot_top sot_top_checker #(.REACT_CYC(REACT_CYC), .SEC_CYC(SEC_CYC)) u_chk
  (.CLK_I, .RST_N_I, .APB_I, .APB_O, .PAY_TAKE_O, .TX_O, .RX_LOS_I,
   .RX_DATA_I, .RX_DATA_O, .RX_AIS_O, .LOS_REP_O, .IRQ_O);

// ==== bench/sot_line_model.sv ====
// Purpose: far-end line equipment feeding the receive pins
// Assumes: bench commands signal loss and section defect
// Notes:   data keeps toggling even while the signal is lost
`timescale 1ns/10ps
module sot_line_model (
  // control
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       los_cmd_i,
  input  wire logic       sd_cmd_i,
  // line
  output logic            los_o,
  output logic            sd_o,
  output logic [7:0]      data_o
);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      los_o <= 1'b0;
      sd_o <= 1'b0;
      data_o <= 8'h00;
    end else begin
      los_o <= los_cmd_i;
      sd_o <= sd_cmd_i;
      data_o <= data_o + 8'h3B;
    end
  end
endmodule : sot_line_model

// ==== bench/sot_top_bench.sv ====
// Purpose: self-checking bench of sot_top
// Assumes: short reaction and interval counts
// Notes:   frame notes are compared after descrambling
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module sot_top_bench;
  import sot_pkg::*;
  localparam int RC = 20;
  localparam int SC = 200;
  typedef struct {logic [31:0] v; logic [31:0] m;} sot_rd_t;
  typedef struct {int p; logic [7:0] v;} sot_fn_t;
  logic         clk;
  logic         rst_n = 1'b0;
  sot_apb_req_t req = '0;
  sot_apb_rsp_t rsp;
  sot_tx_t      tx;
  logic [7:0]   pay = 8'h00;
  logic [7:0]   rxd, rxo;
  logic         take, los, sd, ais, rep, irq;
  logic         los_cmd = 1'b0;
  logic         sd_cmd = 1'b0;
  sot_rd_t      rq[$];
  sot_fn_t      fq[$];
  logic [7:0]   pq[$];
  logic [23:0]  x24, p24;
  int           bad_count, num_checks, cyc, fp, nf;
  logic [6:0]   st;
  logic [7:0]   xr, pb, db, k;

  sot_top #(.REACT_CYC(RC), .SEC_CYC(SC)) DUT (.CLK_I(clk), .RST_N_I(rst_n),
    .APB_I(req), .APB_O(rsp), .PAY_I(pay), .PAY_TAKE_O(take), .TX_O(tx),
    .RX_LOS_I(los), .RX_SD_I(sd), .RX_DATA_I(rxd), .RX_DATA_O(rxo),
    .RX_AIS_O(ais), .LOS_REP_O(rep), .IRQ_O(irq));
  sot_line_model u_line (.clk_i(clk), .rst_n_i(rst_n), .los_cmd_i(los_cmd),
    .sd_cmd_i(sd_cmd), .los_o(los), .sd_o(sd), .data_o(rxd));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (take === 1'b1) pq.push_back(pay);
    pay <= 8'($urandom);
  end
  always @(posedge clk) if (++cyc > 40000) begin
    bad_count++;
    tally_and_finish();
  end

  // ==========================================================
  // monitor
  always @(posedge clk) begin
    fp = tx.fs ? 0 : fp + 1;
    if (tx.fs) begin
      nf++;
      pb = xr;
      xr = 8'h00;
      p24 = x24;
      x24 = 24'h000000;
    end
    xr ^= tx.byte_val;
    if (fp == 9) st = 7'h7F;
    k = 8'h00;
    if (fp >= 9) for (int b = 7; b >= 0; b--) begin
      k[b] = st[6];
      st = {st[5:0], st[6] ^ st[5]};
    end
    db = tx.byte_val ^ k;
    if (fp < 2430 && !(fp < 810 && fp % 270 < 9))
      x24[8*(2 - fp % 270 % 3) +: 8] ^= db;
    if (fp >= 1080 && fp <= 1082 && nf > 1)
      `CHK(db, p24[8*(1082 - fp) +: 8])
    if (nf > 0 && (fp % 270 >= 9 || fp / 270 == 3) && pq.size() > 0) begin
      `CHK(db, pq[0])
      pq.delete(0);
    end
    if (fp == 270 && nf > 1) `CHK(db, pb)
    if (nf > 0 && fq.size() > 0 && fq[0].p == fp) begin
      `CHK(db, fq[0].v)
      fq.delete(0);
    end
    if (rsp.pready && req.psel && !req.pwrite && rq.size() > 0) begin
      `CHK(rsp.prdata & rq[0].m, rq[0].v)
      rq.delete(0);
    end
  end

  // ==========================================================
  // driver tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m = 32'hFFFFFFFF, input logic e = 0);
    if (!w) rq.push_back('{d, m});
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    `CHK(rsp.pslverr, e)
    req <= '0;
  endtask : apb

  task automatic k2(input logic [7:0] v);
    do @(posedge clk); while (tx.fs !== 1'b1);
    fq.push_back('{1086, v});
    while (fq.size() > 0) @(posedge clk);
  endtask : k2

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // scenarios
  initial begin
    logic [7:0] r;
    void'($urandom(32'h117B));
    r = 8'($urandom);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, OFS_CTRL, 32'h0);
    apb(0, 8'h40, 32'h0, 32'hFFFFFFFF, 1'b1);
    for (int i = 0; i < 4; i++) apb(1, OFS_TRACE0 + 8'(4 * i), {4{r}});
    apb(1, OFS_CTRL, 32'h1);
    do @(posedge clk); while (tx.fs !== 1'b1);
    fq.push_back('{6, r});
    sd_cmd <= 1'b1;
    repeat (RC + 10) @(posedge clk);
    k2(8'h06);
    apb(1, OFS_CTRL, 32'h3);
    k2(8'h00);
    apb(1, OFS_CTRL, 32'h1);
    sd_cmd <= 1'b0;
    repeat (RC + 10) @(posedge clk);
    k2(8'h00);
    // align to an interval end so one loss stays in one second
    apb(1, OFS_INT_EN, 32'h4);
    apb(1, OFS_INT_CLR, 32'h7);
    do @(posedge clk); while (irq !== 1'b1);
    apb(1, OFS_INT_CLR, 32'h7);
    apb(1, OFS_INT_EN, 32'h1);
    los_cmd <= 1'b1;
    repeat (RC + 5) @(posedge clk);
    `CHK({rep, irq, rxo}, {2'b11, 8'hFF})
    apb(0, OFS_INT_STAT, 32'h1, 32'h1);
    apb(1, OFS_INT_CLR, 32'h1);
    los_cmd <= 1'b0;
    repeat (RC + 5) @(posedge clk);
    `CHK({irq, ais}, 2'b00)
    repeat (SC + 20) @(posedge clk);
    apb(0, OFS_NDS_CNT, 32'h1);
    apb(0, OFS_NDS_REP, 32'h1);
    apb(1, OFS_CTRL, 32'h4);
    los_cmd <= 1'b1;
    repeat (RC + 5) @(posedge clk);
    `CHK({rep, ais}, 2'b01)
    `CHK(tx.opt, tx.byte_val)
    apb(0, OFS_INT_STAT, 32'h0, 32'h1);
    los_cmd <= 1'b0;
    repeat (RC + 5) @(posedge clk);
    tally_and_finish();
  end
endmodule : sot_top_bench
